// file: include/pid_if.sv
// signals between the sleep controller and its pid core
`timescale 1ns/1ps
interface pid_if;
  import pid_sleep_pkg::*;
  logic tick;
  logic run;
  logic freeze;
  logic invert;
  logic [KP_W-1:0] kp;
  logic [TI_W-1:0] ti;
  logic [TD_W-1:0] td;
  logic [VAL_W-1:0] ref_val;
  logic [VAL_W-1:0] fb;
  logic [VAL_W-1:0] min_spd;
  logic [VAL_W-1:0] max_spd;
  logic [VAL_W-1:0] out;
  modport ctl (output tick, run, freeze, invert, kp, ti, td, ref_val, fb, min_spd, max_spd, input out);
  modport core (input tick, run, freeze, invert, kp, ti, td, ref_val, fb, min_spd, max_spd, output out);
endinterface

// file: include/pid_sleep_pkg.sv
// constants, register map and types for the process loop with sleep control
package pid_sleep_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int VAL_W = 16;
  localparam int KP_W = 9;
  localparam int TI_W = 15;
  localparam int TD_W = 12;
  localparam int DLY_W = 19;
  localparam int CNT_W = 16;
  localparam int ERR_W = 18;
  localparam int ACC_W = 32;
  localparam int SUM_W = 34;
  localparam int PRD_W = 44;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_KP = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TD = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_DLY = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_MARGIN = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STEADY_DLY = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STEADY_BAND = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_REFERENCE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_MIN_SPEED = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_MAX_SPEED = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_STOPMIN_DLY = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_SPEED = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_FEEDBACK = 8'h38;
  // ------------------------------------------------------------
  // ranges and reset values (gain in tenths, times in 0.01 s)
  // ------------------------------------------------------------
  localparam int KP_MAX = 300;
  localparam int KP_RST = 10;
  localparam int KP_SCALE = 10;
  localparam int TI_MIN = 1;
  localparam int TI_MAX = 30000;
  localparam int TI_RST = 100;
  localparam int TD_MAX = 3000;
  localparam int DLY_MAX = 360000;
  localparam int MARGIN_MAX = 10000;
  localparam int VAL_MAX = 65535;
  localparam int ACC_LIM = 1000000000;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_INVERT = 2'h2;
  // status bit positions
  localparam int STAT_SLEEP = 0;
  localparam int STAT_TEST = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_CNT_LSB = 16;
  // ------------------------------------------------------------
  // timing: one control tick is 0.01 s
  // ------------------------------------------------------------
  localparam int TICK_TIME_US = 10000;
  localparam int CLK_MHZ = 25;
  localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_RUN, ST_STEADY, ST_SLEEP} loop_state_t;
endpackage

// file: rtl/pid_core.sv
// discrete pid core, one update per control tick
`timescale 1ns/1ps
module pid_core
  import pid_sleep_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller link
  pid_if.core bus
);
  logic signed [ERR_W-1:0] err;
  logic signed [ERR_W-1:0] err_prev_r;
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [SUM_W-1:0] i_term;
  logic signed [SUM_W-1:0] d_term;
  logic signed [SUM_W-1:0] sum;
  logic signed [PRD_W-1:0] u;
  logic signed [PRD_W-1:0] u_min;
  logic signed [PRD_W-1:0] u_max;
  logic sat_hi;
  logic sat_lo;
  logic [VAL_W-1:0] out_r;

  // ------------------------------------------------------------
  // control law
  // ------------------------------------------------------------
  always_comb begin
    if (bus.invert) begin
      err = $signed({2'b00, bus.fb}) - $signed({2'b00, bus.ref_val});
    end else begin
      err = $signed({2'b00, bus.ref_val}) - $signed({2'b00, bus.fb});
    end
    i_term = SUM_W'(acc_r) / $signed(SUM_W'({1'b0, bus.ti}));
    d_term = $signed(SUM_W'({1'b0, bus.td})) * (SUM_W'(err) - SUM_W'(err_prev_r));
    sum = SUM_W'(err) + i_term + d_term;
    u = (PRD_W'(sum) * $signed(PRD_W'({1'b0, bus.kp}))) / $signed(PRD_W'(KP_SCALE));
    u_min = $signed(PRD_W'({1'b0, bus.min_spd}));
    u_max = $signed(PRD_W'({1'b0, bus.max_spd}));
    sat_hi = (u >= u_max);
    sat_lo = (u <= u_min);
    acc_nxt = acc_r + ACC_W'(err);
    if (acc_nxt > $signed(ACC_W'(ACC_LIM))) begin
      acc_nxt = $signed(ACC_W'(ACC_LIM));
    end else if (acc_nxt < -$signed(ACC_W'(ACC_LIM))) begin
      acc_nxt = -$signed(ACC_W'(ACC_LIM));
    end
  end

  // ------------------------------------------------------------
  // state update
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
      err_prev_r <= '0;
      out_r <= '0;
    end else if (bus.tick) begin
      if (!bus.run) begin
        acc_r <= '0;
        err_prev_r <= '0;
        out_r <= bus.min_spd;
      end else begin
        err_prev_r <= err;
        if (sat_hi) begin
          out_r <= bus.max_spd;
        end else if (sat_lo) begin
          out_r <= bus.min_spd;
        end else begin
          out_r <= u[VAL_W-1:0];
        end
        // hold the sum while saturated in the same direction, else it winds up
        if (!bus.freeze && !(sat_hi && err > 0) && !(sat_lo && err < 0)) begin
          acc_r <= acc_nxt;
        end
      end
    end
  end

  assign bus.out = out_r;
endmodule

// file: rtl/process_pid_sleep_control.sv
// process loop controller with sleep and steady-state test, apb registers
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - mode 0 off, mode 1 normal sense
// - mode 2 runs controller inverted
// - gain 0.0 to 30.0, reset 1.0
// - integral time 0.01 to 300 s, reset 1.00
// - derivative 0 to 30 s, reset zero
// - sleep after full delay at minimum speed
// - sleep delay 0.01 to 3600 s, zero off
// - active sleep delay overrides stop-below-min timer
// - normal wake below reference minus margin
// - inverted wake above reference plus margin
// - wake margin 0 to 10000, reset zero
// - sleep status visible outside
// - steady test after in-band wait delay
// - test steps speed down by band, by one when band is zero
// - error leaving band aborts the test
// - minimum reached: success, sleep if enabled
// - steady band 0 to 10000, reset zero
module process_pid_sleep_control
  import pid_sleep_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // process side
  input wire logic [VAL_W-1:0] feedback,
  output logic [VAL_W-1:0] speed_cmd,
  output logic sleep_status,
  output logic stop_cmd,
  output logic steady_test_active
);
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES_P - 1);

  function automatic logic [31:0] clamp_u(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic [VAL_W-1:0] abs_diff(input logic [VAL_W-1:0] a, input logic [VAL_W-1:0] b);
    logic [VAL_W-1:0] r;
    r = (a > b) ? (a - b) : (b - a);
    return r;
  endfunction

  // ------------------------------------------------------------
  // settings
  // ------------------------------------------------------------
  logic [1:0] mode_r;
  logic [KP_W-1:0] kp_r;
  logic [TI_W-1:0] ti_r;
  logic [TD_W-1:0] td_r;
  logic [DLY_W-1:0] sleep_dly_r;
  logic [VAL_W-1:0] wake_margin_r;
  logic [DLY_W-1:0] steady_dly_r;
  logic [VAL_W-1:0] steady_band_r;
  logic [VAL_W-1:0] ref_r;
  logic [VAL_W-1:0] min_spd_r;
  logic [VAL_W-1:0] max_spd_r;
  logic [DLY_W-1:0] stopmin_dly_r;
  // bus state
  logic wr_en;
  logic [31:0] rd_val;
  logic rd_err;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  // loop state
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [VAL_W-1:0] fb_s1_r;
  logic [VAL_W-1:0] fb_s2_r;
  loop_state_t state_r;
  logic [DLY_W-1:0] sleep_cnt_r;
  logic [DLY_W-1:0] stopmin_cnt_r;
  logic [DLY_W-1:0] steady_cnt_r;
  logic [VAL_W-1:0] test_speed_r;
  logic [CNT_W-1:0] success_cnt_r;
  logic [VAL_W-1:0] speed_cmd_r;
  logic sleep_r;
  logic stop_r;
  logic test_r;
  logic closed;
  logic sleep_on;
  logic steady_on;
  logic at_min;
  logic in_band;
  logic wake;
  logic sleep_due;
  logic steady_due;
  logic [VAL_W-1:0] step;
  logic [VAL_W:0] fb_ext;
  logic [VAL_W:0] ref_ext;
  logic [VAL_W:0] marg_ext;
  pid_if pif();

  // ------------------------------------------------------------
  // apb slave: zero wait states, data staged in the setup cycle
  // ------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_OFF;
      kp_r <= KP_W'(KP_RST);
      ti_r <= TI_W'(TI_RST);
      td_r <= '0;
      sleep_dly_r <= '0;
      wake_margin_r <= '0;
      steady_dly_r <= '0;
      steady_band_r <= '0;
      ref_r <= '0;
      min_spd_r <= '0;
      max_spd_r <= VAL_W'(VAL_MAX);
      stopmin_dly_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_MODE: begin
          // reserved code 3 falls back to off
          mode_r <= (pwdata[1:0] == MODE_NORMAL || pwdata[1:0] == MODE_INVERT) ? pwdata[1:0] : MODE_OFF;
        end
        ADDR_KP: begin
          kp_r <= KP_W'(clamp_u(pwdata, 32'h0, 32'(KP_MAX)));
        end
        ADDR_TI: begin
          ti_r <= TI_W'(clamp_u(pwdata, 32'(TI_MIN), 32'(TI_MAX)));
        end
        ADDR_TD: begin
          td_r <= TD_W'(clamp_u(pwdata, 32'h0, 32'(TD_MAX)));
        end
        ADDR_SLEEP_DLY: begin
          sleep_dly_r <= DLY_W'(clamp_u(pwdata, 32'h0, 32'(DLY_MAX)));
        end
        ADDR_WAKE_MARGIN: begin
          wake_margin_r <= VAL_W'(clamp_u(pwdata, 32'h0, 32'(MARGIN_MAX)));
        end
        ADDR_STEADY_DLY: begin
          steady_dly_r <= DLY_W'(clamp_u(pwdata, 32'h0, 32'(DLY_MAX)));
        end
        ADDR_STEADY_BAND: begin
          steady_band_r <= VAL_W'(clamp_u(pwdata, 32'h0, 32'(MARGIN_MAX)));
        end
        ADDR_REFERENCE: begin
          ref_r <= pwdata[VAL_W-1:0];
        end
        ADDR_MIN_SPEED: begin
          min_spd_r <= pwdata[VAL_W-1:0];
        end
        ADDR_MAX_SPEED: begin
          max_spd_r <= pwdata[VAL_W-1:0];
        end
        ADDR_STOPMIN_DLY: begin
          stopmin_dly_r <= DLY_W'(clamp_u(pwdata, 32'h0, 32'(DLY_MAX)));
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    case (paddr)
      ADDR_MODE: rd_val = 32'(mode_r);
      ADDR_KP: rd_val = 32'(kp_r);
      ADDR_TI: rd_val = 32'(ti_r);
      ADDR_TD: rd_val = 32'(td_r);
      ADDR_SLEEP_DLY: rd_val = 32'(sleep_dly_r);
      ADDR_WAKE_MARGIN: rd_val = 32'(wake_margin_r);
      ADDR_STEADY_DLY: rd_val = 32'(steady_dly_r);
      ADDR_STEADY_BAND: rd_val = 32'(steady_band_r);
      ADDR_REFERENCE: rd_val = 32'(ref_r);
      ADDR_MIN_SPEED: rd_val = 32'(min_spd_r);
      ADDR_MAX_SPEED: rd_val = 32'(max_spd_r);
      ADDR_STOPMIN_DLY: rd_val = 32'(stopmin_dly_r);
      ADDR_STATUS: begin
        rd_val[STAT_SLEEP] = sleep_r;
        rd_val[STAT_TEST] = test_r;
        rd_val[STAT_STOP] = stop_r;
        rd_val[STAT_CNT_LSB +: CNT_W] = success_cnt_r;
      end
      ADDR_SPEED: rd_val = 32'(speed_cmd_r);
      ADDR_FEEDBACK: rd_val = 32'(fb_s2_r);
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
      pready_r <= 1'b1;
    end else begin
      pready_r <= 1'b1;
      if (psel && !penable) begin
        prdata_r <= pwrite ? 32'h0 : rd_val;
        pslverr_r <= rd_err;
      end
    end
  end

  // ------------------------------------------------------------
  // control tick and feedback synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r >= TICK_LAST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  assign tick = (tick_cnt_r == TICK_LAST);

  // word is sampled per bit; sensor value must change slowly against pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_s1_r <= '0;
      fb_s2_r <= '0;
    end else begin
      fb_s1_r <= feedback;
      fb_s2_r <= fb_s1_r;
    end
  end

  // ------------------------------------------------------------
  // conditions
  // ------------------------------------------------------------
  assign closed = (mode_r == MODE_NORMAL) || (mode_r == MODE_INVERT);
  assign sleep_on = (sleep_dly_r != '0);
  assign steady_on = (steady_dly_r != '0);
  assign at_min = (pif.out <= min_spd_r);
  assign in_band = (abs_diff(ref_r, fb_s2_r) <= steady_band_r);
  assign fb_ext = {1'b0, fb_s2_r};
  assign ref_ext = {1'b0, ref_r};
  assign marg_ext = {1'b0, wake_margin_r};
  // compare in sums so a margin above the reference cannot wrap
  assign wake = (mode_r == MODE_INVERT) ? (fb_ext > ref_ext + marg_ext)
                                        : (fb_ext + marg_ext < ref_ext);
  assign sleep_due = sleep_on && (sleep_cnt_r >= sleep_dly_r);
  assign steady_due = steady_on && (steady_cnt_r >= steady_dly_r);
  // a zero band would never reach minimum, so step by one instead
  assign step = (steady_band_r == '0) ? VAL_W'(1) : steady_band_r;

  // ------------------------------------------------------------
  // timers, counted in control ticks
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_cnt_r <= '0;
    end else if (state_r != ST_RUN || !closed || !sleep_on || !at_min) begin
      sleep_cnt_r <= '0;
    end else if (tick && !sleep_due) begin
      sleep_cnt_r <= sleep_cnt_r + DLY_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stopmin_cnt_r <= '0;
    end else if (!closed || sleep_on || !at_min || stopmin_dly_r == '0) begin
      stopmin_cnt_r <= '0;
    end else if (tick && stopmin_cnt_r < stopmin_dly_r) begin
      stopmin_cnt_r <= stopmin_cnt_r + DLY_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steady_cnt_r <= '0;
    end else if (state_r != ST_RUN || !closed || !steady_on || !in_band) begin
      steady_cnt_r <= '0;
    end else if (tick && !steady_due) begin
      steady_cnt_r <= steady_cnt_r + DLY_W'(1);
    end
  end

  // ------------------------------------------------------------
  // sleep and steady test sequence
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      test_speed_r <= '0;
      success_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (closed && sleep_due) begin
            state_r <= ST_SLEEP;
          end else if (closed && steady_due) begin
            state_r <= ST_STEADY;
            test_speed_r <= pif.out;
          end
        end
        ST_STEADY: begin
          if (!closed) begin
            state_r <= ST_RUN;
          end else if (tick) begin
            if (!in_band) begin
              state_r <= ST_RUN;
            end else if (test_speed_r <= min_spd_r + step) begin
              test_speed_r <= min_spd_r;
              success_cnt_r <= success_cnt_r + CNT_W'(1);
              state_r <= sleep_on ? ST_SLEEP : ST_RUN;
            end else begin
              test_speed_r <= test_speed_r - step;
            end
          end
        end
        ST_SLEEP: begin
          if (!closed || wake) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd_r <= '0;
      sleep_r <= 1'b0;
      stop_r <= 1'b0;
      test_r <= 1'b0;
    end else begin
      sleep_r <= (state_r == ST_SLEEP);
      test_r <= (state_r == ST_STEADY);
      stop_r <= stopmin_dly_r != '0 && stopmin_cnt_r >= stopmin_dly_r;
      if (!closed) begin
        speed_cmd_r <= VAL_W'(clamp_u(32'(ref_r), 32'(min_spd_r), 32'(max_spd_r)));
      end else if (state_r == ST_SLEEP) begin
        speed_cmd_r <= '0;
      end else if (state_r == ST_STEADY) begin
        speed_cmd_r <= test_speed_r;
      end else begin
        speed_cmd_r <= pif.out;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign speed_cmd = speed_cmd_r;
  assign sleep_status = sleep_r;
  assign stop_cmd = stop_r;
  assign steady_test_active = test_r;

  // ------------------------------------------------------------
  // pid core
  // ------------------------------------------------------------
  assign pif.tick = tick;
  assign pif.run = closed;
  assign pif.freeze = (state_r != ST_RUN);
  assign pif.invert = (mode_r == MODE_INVERT);
  assign pif.kp = kp_r;
  assign pif.ti = ti_r;
  assign pif.td = td_r;
  assign pif.ref_val = ref_r;
  assign pif.fb = fb_s2_r;
  assign pif.min_spd = min_spd_r;
  assign pif.max_spd = max_spd_r;

  pid_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .bus(pif.core)
  );
endmodule

// file: verification/fb_sensor.sv
// process feedback sensor model
`timescale 1ns/1ps
module fb_sensor
  import pid_sleep_pkg::*;
(
  // clock
  input wire logic pclk,
  // process level set by the bench
  input wire logic [VAL_W-1:0] level,
  // sensor output
  output logic [VAL_W-1:0] feedback
);
  // sampled transducer: the value moves on the clock only
  always_ff @(posedge pclk) begin
    feedback <= level;
  end
endmodule

// file: verification/pid_sleep_monitor.sv
// assertions on the process loop controller ports
`timescale 1ns/1ps
module pid_sleep_monitor
  import pid_sleep_pkg::*;
#(
  parameter int TICK_CYCLES_P = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // process
  input wire logic [VAL_W-1:0] feedback,
  input wire logic [VAL_W-1:0] speed_cmd,
  input wire logic sleep_status,
  input wire logic stop_cmd,
  input wire logic steady_test_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // register shadows
  // ----
  logic [1:0] mode_r;
  logic [VAL_W-1:0] ref_r, min_r, mar_r, band_r;
  logic soff_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= MODE_OFF;
      ref_r <= '0;
      min_r <= '0;
      mar_r <= '0;
      band_r <= '0;
      soff_r <= 1'b1;
    end else if (psel && penable && pwrite && pready) begin
      case (paddr)
        ADDR_MODE: mode_r <= (pwdata[1:0] == 2'h3) ? MODE_OFF : pwdata[1:0];
        ADDR_REFERENCE: ref_r <= pwdata[15:0];
        ADDR_MIN_SPEED: min_r <= pwdata[15:0];
        ADDR_WAKE_MARGIN: mar_r <= (pwdata > 32'h2710) ? 16'h2710 : pwdata[15:0];
        ADDR_SLEEP_DLY: soff_r <= (pwdata == 32'h0);
        ADDR_STEADY_BAND: band_r <= (pwdata > 32'h2710) ? 16'h2710 : pwdata[15:0];
        default: ;
      endcase
    end
  end
  // wide sums, a margin near full scale must not wrap
  wire logic [16:0] fb_m = feedback + mar_r;
  wire logic [16:0] ref_m = ref_r + mar_r;
  wire logic wk_n = fb_m < {1'b0, ref_r};
  wire logic wk_i = {1'b0, feedback} > ref_m;
  // ----
  // properties
  // ----
  property p_zero; sleep_status |-> speed_cmd == 16'h0; endproperty
  a_zero: assert property (p_zero) else $error("speed while asleep");
  property p_entry; $rose(sleep_status) |-> !soff_r && ($past(speed_cmd) == min_r || $past(steady_test_active));
  endproperty
  a_entry: assert property (p_entry) else $error("sleep without cause");
  property p_off; (mode_r == MODE_OFF) [*3] |-> !sleep_status; endproperty
  a_off: assert property (p_off) else $error("asleep with loop off");
  property p_wk_n; (sleep_status && mode_r == MODE_NORMAL && wk_n) [*3] |-> ##[1:3] !sleep_status; endproperty
  a_wk_n: assert property (p_wk_n) else $error("no normal wake");
  property p_wk_i; (sleep_status && mode_r == MODE_INVERT && wk_i) [*3] |-> ##[1:3] !sleep_status; endproperty
  a_wk_i: assert property (p_wk_i) else $error("no inverted wake");
  property p_stay; (sleep_status && mode_r == MODE_NORMAL && !wk_n) [*4] |=> sleep_status; endproperty
  a_stay: assert property (p_stay) else $error("early wake");
  property p_step; steady_test_active |-> speed_cmd >= min_r; endproperty
  a_step: assert property (p_step) else $error("test speed below min");
  property p_dn; steady_test_active && $past(steady_test_active) && speed_cmd != $past(speed_cmd) |->
    speed_cmd == min_r || $past(speed_cmd) - speed_cmd == ((band_r == 16'h0) ? 16'h1 : band_r); endproperty
  a_dn: assert property (p_dn) else $error("test step not the band");
  property p_stop; $rose(stop_cmd) |-> soff_r && mode_r != MODE_OFF; endproperty
  a_stop: assert property (p_stop) else $error("stop timer not overridden");
  c_sleep: cover property ($rose(sleep_status));
  c_test: cover property ($fell(steady_test_active) && !sleep_status);
  c_stop: cover property ($rose(stop_cmd));
endmodule
bind process_pid_sleep_control pid_sleep_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) mon (.pclk, .presetn, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .feedback, .speed_cmd, .sleep_status,
  .stop_cmd, .steady_test_active);

// file: verification/testbench.sv
// self-checking bench for the process loop controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: bad read", $time); end end
module testbench;
  import pid_sleep_pkg::*;
  // ----
  // signals
  // ----
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, stop_cmd, sleep_status, steady_test_active;
  logic [VAL_W-1:0] feedback, speed_cmd;
  logic [VAL_W-1:0] level = '0;
  wire logic [2:0] outs = {stop_cmd, steady_test_active, sleep_status};
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int r;
  localparam logic [ADDR_W-1:0] RA[9] = '{ADDR_MODE, ADDR_KP, ADDR_TI, ADDR_TD, ADDR_SLEEP_DLY, ADDR_WAKE_MARGIN,
    ADDR_STEADY_DLY, ADDR_STEADY_BAND, ADDR_STATUS};
  localparam logic [31:0] RV[9] = '{32'h0, 32'ha, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [ADDR_W-1:0] SA[9] = '{ADDR_KP, ADDR_KP, ADDR_TI, ADDR_TI, ADDR_TD, ADDR_WAKE_MARGIN,
    ADDR_STEADY_BAND, ADDR_MODE, ADDR_SLEEP_DLY};
  localparam logic [31:0] SW[9] = '{32'h0, 32'h1f4, 32'h0, 32'h9c40, 32'h1388, 32'h4e20, 32'h4e20, 32'h3, 32'h61a80};
  localparam logic [31:0] SE[9] = '{32'h0, 32'h12c, 32'h1, 32'h7530, 32'hbb8, 32'h2710, 32'h2710, 32'h0, 32'h57e40};
  initial begin
    forever #20 pclk = ~pclk;
  end
  process_pid_sleep_control #(.TICK_CYCLES_P(4)) dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .feedback, .speed_cmd, .sleep_status, .stop_cmd, .steady_test_active);
  fb_sensor sensor (.pclk, .level, .feedback);
  // ----
  // apb master and waits
  // ----
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] v, input logic err);
    exp_q.push_back({err, m, v});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 3000 && outs[k] !== v; i++) @(posedge pclk);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watcher: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      `CHK({pslverr, prdata & e[63:32]}, {e[64], e[31:0]})
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(6877));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(RA[i], 32'hffffffff, RV[i], 1'b0);
    rd(8'h3c, 32'hffffffff, 32'h0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      wr(SA[i], SW[i]);
      rd(SA[i], 32'hffffffff, SE[i], 1'b0);
    end
    // loop off: speed is the clamped reference, speed register read-only
    for (int i = 0; i < 4; i++) begin
      r = $urandom_range(16'hfff0, 16'h10);
      wr(ADDR_REFERENCE, r);
      wr(ADDR_SPEED, 32'h0);
      rd(ADDR_SPEED, 32'hffff, r, 1'b0);
    end
    wr(ADDR_MIN_SPEED, 32'h32);
    wr(ADDR_REFERENCE, 32'h14);
    rd(ADDR_SPEED, 32'hffff, 32'h32, 1'b0);
    // normal sense: high feedback pins output at minimum
    wr(ADDR_MAX_SPEED, 32'h3e8);
    wr(ADDR_REFERENCE, 32'h64);
    wr(ADDR_WAKE_MARGIN, 32'ha);
    wr(ADDR_SLEEP_DLY, 32'h3);
    level <= 16'h12c;
    wr(ADDR_MODE, MODE_NORMAL);
    wt(0, 1'b1);
    rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
    rd(ADDR_SPEED, 32'hffff, 32'h0, 1'b0);
    level <= 16'h5b;
    repeat (40) @(posedge pclk);
    rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
    level <= 16'h59;
    wt(0, 1'b0);
    rd(ADDR_STATUS, 32'h1, 32'h0, 1'b0);
    // inverted sense: low feedback pins output at minimum
    wr(ADDR_MODE, MODE_OFF);
    level <= 16'h0;
    wr(ADDR_MODE, MODE_INVERT);
    wt(0, 1'b1);
    rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
    level <= 16'h73;
    wt(0, 1'b0);
    rd(ADDR_STATUS, 32'h1, 32'h0, 1'b0);
    // steady test: long sleep delay, so only a test success can put it to sleep
    wr(ADDR_MODE, MODE_OFF);
    level <= 16'h55;
    wr(ADDR_WAKE_MARGIN, 32'h1e);
    wr(ADDR_STEADY_BAND, 32'h14);
    wr(ADDR_STEADY_DLY, 32'h2);
    wr(ADDR_SLEEP_DLY, 32'h57e40);
    wr(ADDR_MODE, MODE_NORMAL);
    wt(1, 1'b1);
    wt(0, 1'b1);
    rd(ADDR_STATUS, 32'hffff0003, 32'h10001, 1'b0);
    level <= 16'h32;
    wt(0, 1'b0);
    level <= 16'h55;
    wt(1, 1'b1);
    level <= 16'h3c;
    wt(1, 1'b0);
    rd(ADDR_STATUS, 32'hffff0003, 32'h10000, 1'b0);
    // stop timer acts only with the sleep delay off
    wr(ADDR_SLEEP_DLY, 32'h0);
    wr(ADDR_STOPMIN_DLY, 32'h3);
    level <= 16'h12c;
    wt(2, 1'b1);
    rd(ADDR_STATUS, 32'h5, 32'h4, 1'b0);
    print_verdict();
  end
endmodule
